// File: inc/cvff_pkg.sv
// Package for the cell voltage fault flag bank.
// Assumes one clock domain and AXI4-Lite register access with 32-bit data.
package cvff_pkg;

	// Bus widths
	localparam int CVFF_ADDR_W = 18;
	localparam int CVFF_DATA_W = 32;
	localparam int CVFF_CELLS  = 16;

	// Register indices; byte address is four times the index
	localparam logic [15:0] CVFF_IDX_UV       = 16'h7F1C;
	localparam logic [15:0] CVFF_IDX_OV       = 16'h7F1E;
	localparam logic [15:0] CVFF_IDX_IRQ_STAT = 16'h7F24;
	localparam logic [15:0] CVFF_IDX_IRQ_MASK = 16'h7F25;

	// Byte addresses derived from the indices
	localparam logic [17:0] CVFF_ADDR_UV       = {CVFF_IDX_UV, 2'b00};
	localparam logic [17:0] CVFF_ADDR_OV       = {CVFF_IDX_OV, 2'b00};
	localparam logic [17:0] CVFF_ADDR_IRQ_STAT = {CVFF_IDX_IRQ_STAT, 2'b00};
	localparam logic [17:0] CVFF_ADDR_IRQ_MASK = {CVFF_IDX_IRQ_MASK, 2'b00};

	// Field positions inside the interrupt status and mask words
	localparam int CVFF_IRQ_UV_LSB = 0;
	localparam int CVFF_IRQ_OV_LSB = 16;

	// Reset values, and the fixed upper half read from the flag words
	localparam logic [15:0] CVFF_FLAGS_RST = 16'h0000;
	localparam logic [31:0] CVFF_STAT_RST  = 32'h00000000;
	localparam logic [31:0] CVFF_MASK_RST  = 32'h00000000;
	localparam logic [15:0] CVFF_RSVD_HI   = 16'h0000;

	// Response codes
	localparam logic [1:0] CVFF_RESP_OKAY   = 2'h0;
	localparam logic [1:0] CVFF_RESP_SLVERR = 2'h2;

	// Per-cell flag pair: under-voltage in the low half, over in the high
	typedef struct packed {
		logic [15:0] ov;
		logic [15:0] uv;
	} cvff_cells_s;

	// Write channel sequencer
	typedef enum logic [1:0] {
		CVFF_WR_WAIT = 2'b01,
		CVFF_WR_RESP = 2'b10
	} cvff_wr_e;

	// Read channel sequencer
	typedef enum logic [1:0] {
		CVFF_RD_IDLE = 2'b01,
		CVFF_RD_DATA = 2'b10
	} cvff_rd_e;

endpackage : cvff_pkg

// File: logic/cvff_live_flags.sv
// Live flag register for one word of per-cell voltage conditions.
// Assumes the conditions come from monitor logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cvff_live_flags
	import cvff_pkg::*;
#(
	parameter int W = CVFF_CELLS
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] cond,
	output logic      [W-1:0] flag_q,
	output logic      [W-1:0] rise
);

	// Flags track the live condition, no latching
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_q <= W'(CVFF_FLAGS_RST);
		end else if (ce) begin
			flag_q <= cond;
		end
	end

	// A flag about to go from clear to set is an event
	assign rise = cond & ~flag_q & {W{ce}};

endmodule : cvff_live_flags

`default_nettype wire

// File: logic/cvff_sticky.sv
// Sticky interrupt status with read-to-clear and mask gating.
// Assumes event and clear pulses are on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cvff_sticky
	import cvff_pkg::*;
#(
	parameter int W = CVFF_DATA_W
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] set,
	input  wire logic         clr,
	input  wire logic [W-1:0] mask,
	output logic      [W-1:0] stat_q,
	output logic              irq
);

	// Set wins over a clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q <= W'(CVFF_STAT_RST);
		end else if (ce) begin
			stat_q <= (stat_q & ~{W{clr}}) | set;
		end
	end

	// Level interrupt while any unmasked bit stands
	assign irq = |(stat_q & mask);

	a_set_not_lost : assert property (@(posedge aclk) disable iff (!aresetn)
		ce && (set != '0) |=> (stat_q & $past(set)) == $past(set))
		else $error("sticky event lost");

endmodule : cvff_sticky

`default_nettype wire

// File: logic/cvff_top.sv
// Cell voltage fault flag bank with AXI4-Lite register access.
// Assumes conditions come from monitor logic clocked by aclk.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module cvff_top
	import cvff_pkg::*;
#(
	parameter int ADDR_W = CVFF_ADDR_W
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic [15:0]       uv_cond,
	input  wire logic [15:0]       ov_cond,
	output cvff_cells_s            cell_flags,
	output logic                   irq,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic [2:0]        s_axi_awprot,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic [2:0]        s_axi_arprot,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	cvff_cells_s       flags_q;
	cvff_cells_s       rise_s;
	logic [31:0]       stat_w;
	logic [31:0]       mask_q;
	logic              stat_clr;
	cvff_wr_e          wr_state_q;
	cvff_rd_e          rd_state_q;
	logic              aw_got_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_got_q;
	logic [31:0]       w_data_q;
	logic [3:0]        w_strb_q;
	logic [1:0]        bresp_q;
	logic [31:0]       rdata_q;
	logic [1:0]        rresp_q;
	logic              aw_hs;
	logic              w_hs;
	logic              ar_hs;
	logic              wr_commit;
	logic [15:0]       wr_idx;
	logic [15:0]       rd_idx;
	logic              wr_hit;
	logic [31:0]       rd_word;
	logic [1:0]        rd_resp;
	logic              unused_prot;

	// Protection bits carry no meaning here
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

	// Under-voltage flags, cell n at bit n-1
	cvff_live_flags #(
		.W (CVFF_CELLS)
	) u_uv_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.cond    (uv_cond),
		.flag_q  (flags_q.uv),
		.rise    (rise_s.uv)
	);

	// Over-voltage flags, same layout
	cvff_live_flags #(
		.W (CVFF_CELLS)
	) u_ov_flags (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.cond    (ov_cond),
		.flag_q  (flags_q.ov),
		.rise    (rise_s.ov)
	);

	// Flags leave the block straight from their flip-flops
	assign cell_flags = flags_q;

	// Sticky event status; each rising flag sets its bit
	cvff_sticky #(
		.W (CVFF_DATA_W)
	) u_sticky (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.set     (rise_s),
		.clr     (stat_clr),
		.mask    (mask_q),
		.stat_q  (stat_w),
		.irq     (irq)
	);

	// Channel handshakes; a frozen block accepts nothing
	assign s_axi_awready = ce && (wr_state_q == CVFF_WR_WAIT) && !aw_got_q;
	assign s_axi_wready  = ce && (wr_state_q == CVFF_WR_WAIT) && !w_got_q;
	assign s_axi_arready = ce && (rd_state_q == CVFF_RD_IDLE);
	assign aw_hs         = s_axi_awvalid && s_axi_awready;
	assign w_hs          = s_axi_wvalid && s_axi_wready;
	assign ar_hs         = s_axi_arvalid && s_axi_arready;
	assign wr_commit     = ce && (wr_state_q == CVFF_WR_WAIT)
		&& aw_got_q && w_got_q;

	// Word index of each access
	assign wr_idx = aw_addr_q[17:2];
	assign rd_idx = s_axi_araddr[17:2];

	// Write address and data are held until both have arrived
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_q  <= 1'b0;
			aw_addr_q <= '0;
		end else if (ce) begin
			if (aw_hs) begin
				aw_got_q  <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (wr_commit) begin
				aw_got_q <= 1'b0;
			end
		end
	end

	// Write data holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_q  <= 1'b0;
			w_data_q <= '0;
			w_strb_q <= '0;
		end else if (ce) begin
			if (w_hs) begin
				w_got_q  <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (wr_commit) begin
				w_got_q <= 1'b0;
			end
		end
	end

	// Flag words accept writes but store nothing
	assign wr_hit = (wr_idx == CVFF_IDX_UV) || (wr_idx == CVFF_IDX_OV)
		|| (wr_idx == CVFF_IDX_IRQ_STAT)
		|| (wr_idx == CVFF_IDX_IRQ_MASK);

	// Write sequencer: commit, then answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_state_q <= CVFF_WR_WAIT;
			bresp_q    <= CVFF_RESP_OKAY;
		end else if (ce) begin
			case (wr_state_q)
				CVFF_WR_WAIT: begin
					if (wr_commit) begin
						wr_state_q <= CVFF_WR_RESP;
						bresp_q    <= wr_hit ? CVFF_RESP_OKAY
							: CVFF_RESP_SLVERR;
					end
				end
				CVFF_WR_RESP: begin
					if (s_axi_bready) begin
						wr_state_q <= CVFF_WR_WAIT;
					end
				end
				default: begin
					wr_state_q <= CVFF_WR_WAIT;
				end
			endcase
		end
	end

	assign s_axi_bvalid = (wr_state_q == CVFF_WR_RESP);
	assign s_axi_bresp  = bresp_q;

	// Interrupt mask, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask_q <= CVFF_MASK_RST;
		end else if (ce && wr_commit && (wr_idx == CVFF_IDX_IRQ_MASK)) begin
			for (int b = 0; b < 4; b++) begin
				if (w_strb_q[b]) begin
					mask_q[8*b +: 8] <= w_data_q[8*b +: 8];
				end
			end
		end
	end

	// A full-lane write to the mask lands on the next edge
	a_mask_write : assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_commit && (wr_idx == CVFF_IDX_IRQ_MASK) && (w_strb_q == 4'hF)
		|=> mask_q == $past(w_data_q))
		else $error("mask write not stored");

	// Read word selection; upper half of flag words reads zero
	always_comb begin
		rd_word = '0;
		rd_resp = CVFF_RESP_OKAY;
		case (rd_idx)
			CVFF_IDX_UV: begin
				rd_word = {CVFF_RSVD_HI, flags_q.uv};
			end
			CVFF_IDX_OV: begin
				rd_word = {CVFF_RSVD_HI, flags_q.ov};
			end
			CVFF_IDX_IRQ_STAT: begin
				rd_word = stat_w;
			end
			CVFF_IDX_IRQ_MASK: begin
				rd_word = mask_q;
			end
			default: begin
				rd_resp = CVFF_RESP_SLVERR;
			end
		endcase
	end

	// Reading the status word clears what it returned
	assign stat_clr = ar_hs && (rd_idx == CVFF_IDX_IRQ_STAT);

	// After a status read only events of the accept cycle may stand
	a_stat_read_clear : assert property (@(posedge aclk)
		disable iff (!aresetn)
		stat_clr |=> (stat_w & ~$past(rise_s)) == '0)
		else $error("status not cleared by read");

	// Read sequencer: capture word, hold until taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= CVFF_RD_IDLE;
			rdata_q    <= '0;
			rresp_q    <= CVFF_RESP_OKAY;
		end else if (ce) begin
			case (rd_state_q)
				CVFF_RD_IDLE: begin
					if (ar_hs) begin
						rd_state_q <= CVFF_RD_DATA;
						rdata_q    <= rd_word;
						rresp_q    <= rd_resp;
					end
				end
				CVFF_RD_DATA: begin
					if (s_axi_rready) begin
						rd_state_q <= CVFF_RD_IDLE;
					end
				end
				default: begin
					rd_state_q <= CVFF_RD_IDLE;
				end
			endcase
		end
	end

	assign s_axi_rvalid = (rd_state_q == CVFF_RD_DATA);
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

	// Under-voltage word read returns the flags of the accept cycle
	a_uv_read_word : assert property (@(posedge aclk)
		disable iff (!aresetn)
		ar_hs && (rd_idx == CVFF_IDX_UV)
		|=> s_axi_rvalid && (s_axi_rdata == {16'h0000, $past(flags_q.uv)}))
		else $error("under-voltage word read mismatch");

	// Each under-voltage flag follows its cell one cycle later
	a_uv_flag_live : assert property (@(posedge aclk)
		disable iff (!aresetn)
		ce |=> flags_q.uv == $past(uv_cond))
		else $error("under-voltage flag not tracking cell");

	// Over-voltage word read returns the flags of the accept cycle
	a_ov_read_word : assert property (@(posedge aclk)
		disable iff (!aresetn)
		ar_hs && (rd_idx == CVFF_IDX_OV)
		|=> s_axi_rvalid && (s_axi_rdata == {16'h0000, $past(flags_q.ov)}))
		else $error("over-voltage word read mismatch");

	// Over-voltage flag 15 is set by the second cycle of its condition
	a_ov_flag_live : assert property (@(posedge aclk)
		disable iff (!aresetn)
		(ce && ov_cond[15]) [*2] |-> flags_q.ov[15])
		else $error("over-voltage flag missing");

	// Each over-voltage flag follows its cell one cycle later
	a_ov_flag_track : assert property (@(posedge aclk)
		disable iff (!aresetn)
		ce |=> flags_q.ov == $past(ov_cond))
		else $error("over-voltage flag not tracking cell");

	// A write to a flag word changes neither mask nor flags
	a_ro_write_kept : assert property (@(posedge aclk)
		disable iff (!aresetn)
		wr_commit && ((wr_idx == CVFF_IDX_UV) || (wr_idx == CVFF_IDX_OV))
		|=> (mask_q == $past(mask_q))
			&& (flags_q == {$past(ov_cond), $past(uv_cond)})
			&& (s_axi_bresp == CVFF_RESP_OKAY) && s_axi_bvalid)
		else $error("write to read-only flags had an effect");

	// Flags and status clear at reset
	a_reset_zero : assert property (@(posedge aclk)
		!aresetn |=> (flags_q == '0) && (stat_w == '0) && !irq)
		else $error("flags not zero after reset");

	// Flags drop once all conditions are gone
	a_no_latch : assert property (@(posedge aclk)
		disable iff (!aresetn)
		ce && (uv_cond == '0) && (ov_cond == '0) |=> flags_q == '0)
		else $error("flag latched after condition ended");

	// Write answer holds until taken
	a_bvalid_hold : assert property (@(posedge aclk)
		disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
			&& $stable(s_axi_bresp))
		else $error("write response dropped early");

	// A low enable freezes flags, status, mask and both sequencers
	a_ce_freeze : assert property (@(posedge aclk)
		disable iff (!aresetn)
		!ce |=> $stable(flags_q) && $stable(stat_w) && $stable(mask_q)
			&& $stable(wr_state_q) && $stable(rd_state_q))
		else $error("state moved while enable was low");

endmodule : cvff_top

`default_nettype wire

// File: tb/cvff_top_test.sv
// Self-checking bench for the cell voltage fault flag bank.
// Assumes cvff_pkg is compiled first; the bench is the AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none

// Compare two values and count the outcome
`define CHK(g, e) begin \
	n_checks++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("MISMATCH t=%0t got %h exp %h", $time, g, e); \
	end \
end

module cvff_top_test
	import cvff_pkg::*;
();
	logic        aclk, aresetn, ce, irq;
	logic [15:0] uv_cond, ov_cond;
	cvff_cells_s cell_flags;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0]  s_axi_awprot, s_axi_arprot;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          bad_count = 0;
	int          n_checks = 0;
	int          cycles = 0;

	// Device under test
	cvff_top dut_u (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.ce            (ce),
		.uv_cond       (uv_cond),
		.ov_cond       (ov_cond),
		.cell_flags    (cell_flags),
		.irq           (irq),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awprot  (s_axi_awprot),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arprot  (s_axi_arprot),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready)
	);

	// Clock at 250 MHz
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Verdict and end of run
	task automatic test_done();
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// Hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			test_done();
		end
	end

	// One write: address and data offered together, held until taken
	task automatic wr(input logic [17:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr

	// One read: data and response taken at the edge of the answer
	task automatic rd(input logic [17:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	// Read and compare word and response
	task automatic rd_chk(input logic [17:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(d, e)
		`CHK(r, er)
	endtask : rd_chk

	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		aresetn = 1'b0;
		ce = 1'b1;
		uv_cond = 16'h0000;
		ov_cond = 16'h0000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awprot, s_axi_arprot} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		// Everything clear after reset
		rd_chk(CVFF_ADDR_UV, 32'h00000000, CVFF_RESP_OKAY);
		rd_chk(CVFF_ADDR_OV, 32'h00000000, CVFF_RESP_OKAY);
		`CHK(cell_flags, 32'h00000000)
		`CHK(irq, 1'b0)
		rd_chk(CVFF_ADDR_IRQ_MASK, CVFF_MASK_RST, CVFF_RESP_OKAY);
		// Walk one cell through both words, opposite directions
		for (int i = 0; i < 16; i++) begin
			@(posedge aclk);
			uv_cond <= 16'h0001 << i;
			ov_cond <= 16'h8000 >> i;
			repeat (2) @(posedge aclk);
			`CHK(cell_flags.uv, 16'h0001 << i)
			`CHK(cell_flags.ov, 16'h8000 >> i)
			rd_chk(CVFF_ADDR_UV, {16'h0000, 16'h0001 << i},
				CVFF_RESP_OKAY);
			rd_chk(CVFF_ADDR_OV, {16'h0000, 16'h8000 >> i},
				CVFF_RESP_OKAY);
		end
		// Flags drop as soon as the condition ends
		@(posedge aclk);
		uv_cond <= 16'h0000;
		ov_cond <= 16'h0000;
		repeat (2) @(posedge aclk);
		`CHK(cell_flags, 32'h00000000)
		rd_chk(CVFF_ADDR_UV, 32'h00000000, CVFF_RESP_OKAY);
		rd_chk(CVFF_ADDR_OV, 32'h00000000, CVFF_RESP_OKAY);
		// Host writes leave the flag words alone
		uv_cond <= 16'h0800;
		ov_cond <= 16'h0400;
		wr(CVFF_ADDR_UV, 32'h0000F7FF, r);
		`CHK(r, CVFF_RESP_OKAY)
		wr(CVFF_ADDR_OV, 32'hFFFFFBFF, r);
		`CHK(r, CVFF_RESP_OKAY)
		rd_chk(CVFF_ADDR_UV, 32'h00000800, CVFF_RESP_OKAY);
		rd_chk(CVFF_ADDR_OV, 32'h00000400, CVFF_RESP_OKAY);
		// Unmapped place answers with an error
		rd_chk(18'h00100, 32'h00000000, CVFF_RESP_SLVERR);
		wr(18'h00100, 32'hFFFFFFFF, r);
		`CHK(r, CVFF_RESP_SLVERR)
		// Interrupt: clear, mask, raise, read-clear
		@(posedge aclk);
		uv_cond <= 16'h0000;
		ov_cond <= 16'h0000;
		repeat (3) @(posedge aclk);
		rd(CVFF_ADDR_IRQ_STAT, d, r);
		wr(CVFF_ADDR_IRQ_MASK, 32'h00010000, r);
		`CHK(r, CVFF_RESP_OKAY)
		rd_chk(CVFF_ADDR_IRQ_MASK, 32'h00010000, CVFF_RESP_OKAY);
		uv_cond <= 16'h0004;
		repeat (3) @(posedge aclk);
		`CHK(irq, 1'b0)
		rd_chk(CVFF_ADDR_IRQ_STAT, 32'h00000004, CVFF_RESP_OKAY);
		ov_cond <= 16'h0001;
		repeat (3) @(posedge aclk);
		`CHK(irq, 1'b1)
		rd_chk(CVFF_ADDR_IRQ_STAT, 32'h00010000, CVFF_RESP_OKAY);
		@(posedge aclk);
		`CHK(irq, 1'b0)
		rd_chk(CVFF_ADDR_IRQ_STAT, 32'h00000000, CVFF_RESP_OKAY);
		// A low enable holds the flags and refuses the bus
		ce <= 1'b0;
		uv_cond <= 16'h2000;
		repeat (3) @(posedge aclk);
		`CHK(cell_flags.uv, 16'h0004)
		`CHK(s_axi_arready, 1'b0)
		ce <= 1'b1;
		repeat (2) @(posedge aclk);
		`CHK(cell_flags.uv, 16'h2000)
		rd_chk(CVFF_ADDR_IRQ_STAT, 32'h00002000, CVFF_RESP_OKAY);
		// Reset in mid-run clears flags, status and mask
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		`CHK(cell_flags, 32'h00000000)
		`CHK(irq, 1'b0)
		uv_cond <= 16'h0000;
		ov_cond <= 16'h0000;
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(CVFF_ADDR_IRQ_MASK, CVFF_MASK_RST, CVFF_RESP_OKAY);
		rd_chk(CVFF_ADDR_IRQ_STAT, CVFF_STAT_RST, CVFF_RESP_OKAY);
		rd_chk(CVFF_ADDR_UV, 32'h00000000, CVFF_RESP_OKAY);
		test_done();
	end

endmodule : cvff_top_test

`default_nettype wire
